//--- verilog/cwf_map.svh
// register offsets, field positions and constants of the wakeup filter
// assumes a 32-bit apb slave with byte addresses
`ifndef CWF_MAP_SVH
`define CWF_MAP_SVH
`define CWF_CTRL_ADDR 12'h000
`define CWF_TIMEOUT_ADDR 12'h004
`define CWF_STATUS_ADDR 12'h008
`define CWF_EID_ADDR 12'h00c
`define CWF_IDMU_ADDR 12'h010
`define CWF_DLC_ADDR 12'h014
`define CWF_EDL0_ADDR 12'h018
`define CWF_EDL1_ADDR 12'h01c
`define CWF_DMU0_ADDR 12'h020
`define CWF_DMU1_ADDR 12'h024
`define CWF_ERRCNT_ADDR 12'h028
`define CWF_STORE_BASE 12'h040
`define CWF_STORE_TOP 12'h07c
`define CWF_PRESCALE 16'h0018
`define CWF_NMM_FULL 8'h04
`define CWF_EN_BIT 0
`define CWF_MOD_BIT 1
`define CWF_WAKE_BIT 2
`define CWF_FFT_LSB 4
`define CWF_IDENTIFIER_FILTER_TYPE_LSB 6
`define CWF_DFT_LSB 8
`define CWF_MIE_BIT 10
`define CWF_TIE_BIT 11
`define CWF_NMM_LSB 16
`define CWF_MF_BIT 0
`define CWF_TF_BIT 1
`define CWF_ACT_BIT 2
`define CWF_CNT_LSB 8
`define CWF_IDE_BIT 30
`define CWF_RTR_BIT 31
`define CWF_DLCL_LSB 0
`define CWF_DLCH_LSB 8
`endif

//--- verilog/cwf_pkg.sv
// types of the low-power wakeup filter
// assumes cwf_map.svh for numbers
package cwf_pkg;
   typedef struct packed {
      logic ide;
      logic rtr;
      logic fdf;
      logic [28:0] id;
      logic [3:0] dlc;
      logic [63:0] data;
   } cwf_frame_t;
   typedef struct packed {
      logic [3:0] dlc;
      logic ide;
      logic rtr;
      logic [28:0] id;
      logic [63:0] data;
   } cwf_slot_t;
   typedef enum logic [1:0] {
      CWF_IDLE = 2'b00,
      CWF_FILTER = 2'b01,
      CWF_WOKEN = 2'b10
   } cwf_state_t;
endpackage

//--- verilog/cwf_wakeup_filter.sv
// low-power wakeup filter of a can controller with an apb register file
// assumes frames from the bit receiver arrive as one-cycle pulses on pclk
`include "cwf_map.svh"
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - filter mode needs enable and mode bits
// - wakeup event leaves filter mode
// - four groups keep latest frames in order
// - small match count limits used groups
// - short frames padded with zero bytes
// - stored frames carry no timestamp
// - fd frames ignored in filter mode
// - match and timeout flags gated onto wakeup
// - timeout when counter reaches programmed value
// - filtering continues after timeout while tie bit clear
// - eight-bit count of matched frames
// - timeout counter runs after match while mie bit clear
// - types 0 and 1 match single frame
// - type 2 needs count of id matches
// - ide rtr compared under mask
// - identifier equal, above, below or range
// - length code inside low high bounds
// - data equal, above, below or range
// - short data compared zero extended
// - receive errors count, transmit frozen while filtering
module cwf_wakeup_filter (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_valid,
   input wire cwf_pkg::cwf_frame_t rx_frame,
   input wire logic rx_error,
   input wire logic tx_error,
   input wire logic cpu_awake,
   output logic lp_filter_active,
   output logic wakeup_irq
);
   logic [31:0] ctrl_q, tmo_q, eid_q, idmu_q, dlc_q, edl0_q, edl1_q, dmu0_q, dmu1_q;
   logic mf_q, tf_q;
   logic [7:0] mcnt_q, hits_q, rxerr_q, txerr_q;
   logic [15:0] tcnt_q, pre_q;
   logic [1:0] wptr_q;
   cwf_pkg::cwf_slot_t slot_q [4];
   cwf_pkg::cwf_state_t state_q;
   logic wr, rd, en_mode, filt_on, wake_evt, tick;
   logic id_ok, ir_ok, dlc_ok, dat_ok, short_ok, full_ok, hit, match_evt, tmo_evt;
   logic [1:0] frame_filter_type, identifier_filter_type, dft;
   logic [7:0] match_count_setting;
   logic [63:0] rx_data;

   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign frame_filter_type = ctrl_q[`CWF_FFT_LSB+:2];
   assign identifier_filter_type = ctrl_q[`CWF_IDENTIFIER_FILTER_TYPE_LSB+:2];
   assign dft = ctrl_q[`CWF_DFT_LSB+:2];
   assign match_count_setting = ctrl_q[`CWF_NMM_LSB+:8];
   assign en_mode = ctrl_q[`CWF_EN_BIT] && ctrl_q[`CWF_MOD_BIT];
   assign filt_on = state_q == cwf_pkg::CWF_FILTER;
   assign lp_filter_active = filt_on;

   // byte-lane merge for writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            r[i*8+:8] = nw[i*8+:8];
         end
      end
      return r;
   endfunction

   // compare by filter type: masked equal, at least, at most, inclusive range
   function automatic logic cmp64(input logic [1:0] t, input logic [63:0] v,
                                  input logic [63:0] e, input logic [63:0] m);
      logic r;
      r = 1'b0;
      unique case (t)
         2'b00: r = ((v ^ e) & m) == 64'h0;
         2'b01: r = v >= e;
         2'b10: r = v <= e;
         2'b11: r = (v >= e) && (v <= m);
      endcase
      return r;
   endfunction

   // zero the bytes beyond the length code
   function automatic logic [63:0] pad(input logic [63:0] d, input logic [3:0] n);
      logic [63:0] r;
      r = 64'h0;
      for (int i = 0; i < 8; i++) begin
         if (4'(i) < n) begin
            r[i*8+:8] = d[i*8+:8];
         end
      end
      return r;
   endfunction

   // one word of a storage group: control, identifier, data low, data high
   function automatic logic [31:0] slot_word(input cwf_pkg::cwf_slot_t s,
                                             input logic [1:0] w);
      logic [31:0] r;
      r = 32'h0;
      unique case (w)
         2'b00: r = {24'h0, s.dlc, 2'b00, s.rtr, s.ide};
         2'b01: r = {3'h0, s.id};
         2'b10: r = s.data[31:0];
         2'b11: r = s.data[63:32];
      endcase
      return r;
   endfunction

   assign rx_data = pad(rx_frame.data, rx_frame.dlc);
   assign ir_ok = (((rx_frame.ide ^ eid_q[`CWF_IDE_BIT]) & idmu_q[`CWF_IDE_BIT]) == 1'b0) &&
                  (((rx_frame.rtr ^ eid_q[`CWF_RTR_BIT]) & idmu_q[`CWF_RTR_BIT]) == 1'b0);
   assign id_ok = cmp64(identifier_filter_type, {35'h0, rx_frame.id}, {35'h0, eid_q[28:0]},
                        {35'h0, idmu_q[28:0]});
   assign dlc_ok = (rx_frame.dlc >= dlc_q[`CWF_DLCL_LSB+:4]) &&
                   (rx_frame.dlc <= dlc_q[`CWF_DLCH_LSB+:4]);
   assign dat_ok = cmp64(dft, rx_data, {edl1_q, edl0_q}, {dmu1_q, dmu0_q});
   assign short_ok = ir_ok && id_ok;
   assign full_ok = short_ok && dlc_ok && dat_ok;
   assign hit = filt_on && rx_valid && !rx_frame.fdf && (frame_filter_type[0] ? full_ok : short_ok);
   assign match_evt = hit && (!frame_filter_type[1] || ((hits_q + 8'h01) >= match_count_setting));
   // a zero timeout never fires, also not when the counter saturates
   assign tmo_evt = filt_on && tick && (tmo_q[15:0] != 16'h0) &&
                    (tcnt_q + 16'h0001 == tmo_q[15:0]);
   assign wake_evt = (match_evt && ctrl_q[`CWF_MIE_BIT]) ||
                     (tmo_evt && ctrl_q[`CWF_TIE_BIT]);
   assign wakeup_irq = (mf_q && ctrl_q[`CWF_MIE_BIT]) || (tf_q && ctrl_q[`CWF_TIE_BIT]);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= cwf_pkg::CWF_IDLE;
      end else begin
         unique case (state_q)
            cwf_pkg::CWF_IDLE: begin
               if (en_mode) begin
                  state_q <= cwf_pkg::CWF_FILTER;
               end
            end
            cwf_pkg::CWF_FILTER: begin
               if (!en_mode) begin
                  state_q <= cwf_pkg::CWF_IDLE;
               end else if (wake_evt) begin
                  state_q <= cwf_pkg::CWF_WOKEN;
               end
            end
            cwf_pkg::CWF_WOKEN: begin
               if (!en_mode) begin
                  state_q <= cwf_pkg::CWF_IDLE;
               end
            end
            default: state_q <= cwf_pkg::CWF_IDLE;
         endcase
      end
   end

   // timeout counter keeps running after a match until cpu wakes or filter mode ends
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_q <= 16'h0;
         tcnt_q <= 16'h0;
      end else if (!filt_on || cpu_awake) begin
         pre_q <= 16'h0;
         tcnt_q <= 16'h0;
      end else begin
         pre_q <= tick ? 16'h0 : pre_q + 16'h0001;
         if (tick && tcnt_q != 16'hffff) begin
            tcnt_q <= tcnt_q + 16'h0001;
         end
      end
   end
   assign tick = pre_q == `CWF_PRESCALE;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hits_q <= 8'h0;
         mcnt_q <= 8'h0;
         wptr_q <= 2'b00;
      end else if (state_q == cwf_pkg::CWF_IDLE && en_mode) begin
         hits_q <= 8'h0;
         mcnt_q <= 8'h0;
         wptr_q <= 2'b00;
      end else if (hit) begin
         hits_q <= hits_q + 8'h01;
         if (mcnt_q != 8'hff) begin
            mcnt_q <= mcnt_q + 8'h01;
         end
         if (match_count_setting != 8'h0 && (match_count_setting >= `CWF_NMM_FULL || {6'h0, wptr_q} + 8'h01 < match_count_setting)) begin
            wptr_q <= wptr_q + 2'b01;
         end else begin
            wptr_q <= 2'b00;
         end
      end
   end

   // frame storage: latest frames only, no timestamp kept
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 4; i++) begin
            slot_q[i] <= '0;
         end
      end else if (hit && match_count_setting != 8'h0) begin
         slot_q[wptr_q] <= '{dlc: rx_frame.dlc, ide: rx_frame.ide, rtr: rx_frame.rtr,
                            id: rx_frame.id, data: rx_data};
      end
   end

   // error counters: receive side counts, transmit side frozen while filtering
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxerr_q <= 8'h0;
         txerr_q <= 8'h0;
      end else begin
         if (rx_error && rxerr_q != 8'hff) begin
            rxerr_q <= rxerr_q + 8'h01;
         end
         if (tx_error && !filt_on && txerr_q != 8'hff) begin
            txerr_q <= txerr_q + 8'h01;
         end
      end
   end

   // sticky flags, write one to clear, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mf_q <= 1'b0;
         tf_q <= 1'b0;
      end else begin
         if (match_evt) begin
            mf_q <= 1'b1;
         end else if (wr && paddr == `CWF_STATUS_ADDR && pstrb[0] && pwdata[`CWF_MF_BIT]) begin
            mf_q <= 1'b0;
         end
         if (tmo_evt) begin
            tf_q <= 1'b1;
         end else if (wr && paddr == `CWF_STATUS_ADDR && pstrb[0] && pwdata[`CWF_TF_BIT]) begin
            tf_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= 32'h0;
         tmo_q <= 32'h0;
         eid_q <= 32'h0;
         idmu_q <= 32'h0;
         dlc_q <= 32'h0;
         edl0_q <= 32'h0;
         edl1_q <= 32'h0;
         dmu0_q <= 32'h0;
         dmu1_q <= 32'h0;
      end else if (wr) begin
         unique case (paddr)
            `CWF_CTRL_ADDR: ctrl_q <= merge(ctrl_q, pwdata, pstrb) & 32'h00ff0ff3;
            `CWF_TIMEOUT_ADDR: tmo_q <= merge(tmo_q, pwdata, pstrb) & 32'h0000ffff;
            `CWF_EID_ADDR: eid_q <= merge(eid_q, pwdata, pstrb) & 32'hdfffffff;
            `CWF_IDMU_ADDR: idmu_q <= merge(idmu_q, pwdata, pstrb) & 32'hdfffffff;
            `CWF_DLC_ADDR: dlc_q <= merge(dlc_q, pwdata, pstrb) & 32'h00000f0f;
            `CWF_EDL0_ADDR: edl0_q <= merge(edl0_q, pwdata, pstrb);
            `CWF_EDL1_ADDR: edl1_q <= merge(edl1_q, pwdata, pstrb);
            `CWF_DMU0_ADDR: dmu0_q <= merge(dmu0_q, pwdata, pstrb);
            `CWF_DMU1_ADDR: dmu1_q <= merge(dmu1_q, pwdata, pstrb);
            default: ;
         endcase
      end
   end

   // read data registered at setup, valid in access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         pslverr <= 1'b0;
      end else if (psel && !penable) begin
         pslverr <= 1'b0;
         prdata <= 32'h0;
         if (rd) begin
            unique case (paddr)
               `CWF_CTRL_ADDR: prdata <= ctrl_q | {29'h0, state_q == cwf_pkg::CWF_WOKEN, 2'b00};
               `CWF_TIMEOUT_ADDR: prdata <= tmo_q;
               `CWF_STATUS_ADDR: prdata <= {16'h0, mcnt_q, 5'h0, filt_on, tf_q, mf_q};
               `CWF_EID_ADDR: prdata <= eid_q;
               `CWF_IDMU_ADDR: prdata <= idmu_q;
               `CWF_DLC_ADDR: prdata <= dlc_q;
               `CWF_EDL0_ADDR: prdata <= edl0_q;
               `CWF_EDL1_ADDR: prdata <= edl1_q;
               `CWF_DMU0_ADDR: prdata <= dmu0_q;
               `CWF_DMU1_ADDR: prdata <= dmu1_q;
               `CWF_ERRCNT_ADDR: prdata <= {16'h0, txerr_q, rxerr_q};
               default: begin
                  if (paddr >= `CWF_STORE_BASE && paddr <= `CWF_STORE_TOP && paddr[1:0] == 2'b00) begin
                     prdata <= slot_word(slot_q[paddr[5:4]], paddr[3:2]);
                  end else begin
                     pslverr <= 1'b1;
                  end
               end
            endcase
         end else if (!(paddr < `CWF_ERRCNT_ADDR && paddr[1:0] == 2'b00)) begin
            pslverr <= 1'b1;
         end
      end
   end

   chk_fd_ignored: assert property (@(posedge pclk) disable iff (!presetn)
      (rx_valid && rx_frame.fdf) |=> $stable(mcnt_q))
      else $error("fd frame counted");
   chk_count_incr: assert property (@(posedge pclk) disable iff (!presetn)
      (hit && mcnt_q != 8'hff && !(state_q == cwf_pkg::CWF_IDLE))
      |=> mcnt_q == $past(mcnt_q) + 8'h01)
      else $error("match count not advanced");
   chk_count_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == cwf_pkg::CWF_IDLE && en_mode) |=> mcnt_q == 8'h0)
      else $error("match count not cleared at entry");
   chk_flag_match: assert property (@(posedge pclk) disable iff (!presetn)
      match_evt |=> mf_q)
      else $error("match flag not set");
   chk_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      (mf_q && !wr) |=> mf_q)
      else $error("match flag lost");
   chk_flag_tmo: assert property (@(posedge pclk) disable iff (!presetn)
      tmo_evt |=> tf_q)
      else $error("timeout flag not set");
   chk_timeout_count: assert property (@(posedge pclk) disable iff (!presetn)
      (tmo_evt && !cpu_awake) |=> tcnt_q == $past(tmo_q[15:0]))
      else $error("timeout at wrong count");
   chk_timer_runs: assert property (@(posedge pclk) disable iff (!presetn)
      (filt_on && !cpu_awake && tick && tcnt_q != 16'hffff)
      |=> tcnt_q == $past(tcnt_q) + 16'h0001)
      else $error("timeout counter stalled");
   chk_timer_awake: assert property (@(posedge pclk) disable iff (!presetn)
      cpu_awake |=> tcnt_q == 16'h0)
      else $error("timeout counter kept while awake");
   chk_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
      wakeup_irq |-> (mf_q || tf_q))
      else $error("irq without flag");
   chk_single_match: assert property (@(posedge pclk) disable iff (!presetn)
      (hit && !frame_filter_type[1]) |=> mf_q)
      else $error("single frame did not match");
   chk_mode_entry: assert property (@(posedge pclk) disable iff (!presetn)
      filt_on |-> $past(en_mode))
      else $error("filter without enable");
   chk_mode_exit: assert property (@(posedge pclk) disable iff (!presetn)
      !en_mode |=> !filt_on)
      else $error("filter kept without enable");
   chk_wake_leave: assert property (@(posedge pclk) disable iff (!presetn)
      (filt_on && en_mode && wake_evt) |=> !filt_on)
      else $error("wakeup kept mode");
   chk_pad_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (rx_valid && rx_frame.dlc < 4'h8) |-> (rx_data >> {rx_frame.dlc, 3'b000}) == 64'h0)
      else $error("short frame not zero padded");
   chk_store_id: assert property (@(posedge pclk) disable iff (!presetn)
      (hit && match_count_setting != 8'h0) |=> slot_q[$past(wptr_q)].id == $past(rx_frame.id))
      else $error("stored identifier wrong");
   chk_rx_err_count: assert property (@(posedge pclk) disable iff (!presetn)
      (rx_error && rxerr_q != 8'hff) |=> rxerr_q == $past(rxerr_q) + 8'h01)
      else $error("rx error not counted");
   chk_tx_frozen: assert property (@(posedge pclk) disable iff (!presetn)
      filt_on |=> $stable(txerr_q))
      else $error("tx errors counted");
   chk_ptr_limit: assert property (@(posedge pclk) disable iff (!presetn)
      (match_count_setting != 8'h0 && match_count_setting < `CWF_NMM_FULL) |-> ({6'h0, wptr_q} < match_count_setting || $changed(match_count_setting)))
      else $error("group beyond match count");
endmodule
`default_nettype wire

//--- dv/cwf_frame_source.sv
// model of the bit receiver handing frames from other can nodes to the filter
// assumes the bench calls send from its own process, clocked by pclk
`timescale 1ns/1ps
`default_nettype none
module cwf_frame_source (
   input wire logic pclk,
   output logic rx_valid,
   output cwf_pkg::cwf_frame_t rx_frame
);
   initial begin
      rx_valid = 1'b0;
      rx_frame = '0;
   end
   task automatic send(input logic ide, input logic fdf, input logic [28:0] id,
                       input logic [3:0] dlc, input logic [63:0] d);
      cwf_pkg::cwf_frame_t f;
      f = '{ide: ide, rtr: 1'b0, fdf: fdf, id: id, dlc: dlc, data: d};
      // bytes past the length code carry junk, as a receive buffer may
      for (int i = 0; i < 8; i++) begin
         if (i >= dlc) begin
            f.data[i*8 +: 8] = 8'ha5;
         end
      end
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_frame <= f;
      @(posedge pclk);
      rx_valid <= 1'b0;
      // released lines show the inverse, never a stale copy
      rx_frame <= ~f;
   endtask
endmodule
`default_nettype wire

//--- dv/can_low_power_wakeup_filter_test.sv
// self-checking bench of the wakeup filter: apb accesses and frames in sequence
// assumes cwf_frame_source stands in for the bit receiver
`include "cwf_map.svh"
`timescale 1ns/1ps
`default_nettype none
module can_low_power_wakeup_filter_test;
   localparam logic [11:0] ct = `CWF_CTRL_ADDR;
   localparam logic [11:0] st = `CWF_STATUS_ADDR;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, rx_valid, lp_filter_active, wakeup_irq, last_err;
   logic rx_error = 1'b0;
   logic tx_error = 1'b0;
   logic cpu_awake = 1'b0;
   cwf_pkg::cwf_frame_t rx_frame;
   int num_errors = 0;
   int checked = 0;
   always #20 pclk = ~pclk;
   cwf_frame_source src (.pclk(pclk), .rx_valid(rx_valid), .rx_frame(rx_frame));
   cwf_wakeup_filter dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_frame(rx_frame),
      .rx_error(rx_error), .tx_error(tx_error), .cpu_awake(cpu_awake),
      .lp_filter_active(lp_filter_active), .wakeup_irq(wakeup_irq));
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask
   task automatic rd(input string s, input logic [11:0] a, input logic [31:0] e);
      logic [31:0] r;
      apb(1'b0, a, 32'h0, r);
      chk(s, e, r);
   endtask
   function automatic logic [31:0] cf(input logic [1:0] ft, it, dt, input logic mie, tie,
                                      input logic [7:0] match_count_setting);
      return {8'h00, match_count_setting, 4'h0, tie, mie, dt, it, ft, 4'h3};
   endfunction
   task automatic run(input logic [1:0] ft, it, dt, input logic ide, input logic [28:0] id,
                      input logic [3:0] dlc, input logic [63:0] d, input logic e);
      wr(ct, 32'h0);
      wr(st, 32'h3);
      wr(ct, cf(ft, it, dt, 1'b0, 1'b0, 8'h04));
      src.send(ide, 1'b0, id, dlc, d);
      rd("filter status", st, {16'h0, 7'h0, e, 5'h0, 1'b1, 1'b0, e});
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge pclk);
      num_errors++;
      end_of_test();
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rd("ctrl reset", ct, 32'h0);
      rd("status reset", st, 32'h0);
      wr(12'h030, 32'h1);
      chk("unmapped error", 32'h1, {31'h0, last_err});
      wr(`CWF_ERRCNT_ADDR, 32'hff);
      chk("read-only error", 32'h1, {31'h0, last_err});
      wr(ct, 32'h1);
      repeat (2) @(posedge pclk);
      chk("active enable only", 32'h0, {31'h0, lp_filter_active});
      wr(`CWF_EID_ADDR, 32'h100);
      wr(`CWF_IDMU_ADDR, 32'hc000_0200);
      wr(`CWF_DLC_ADDR, 32'h0802);
      wr(`CWF_EDL0_ADDR, 32'h1234);
      wr(`CWF_EDL1_ADDR, 32'h0);
      wr(`CWF_DMU0_ADDR, 32'hffff);
      wr(`CWF_DMU1_ADDR, 32'h0);
      run(2'h0, 2'h0, 2'h0, 1'h0, 29'h100, 4'h2, 64'h0, 1'h1);
      run(2'h0, 2'h0, 2'h0, 1'h0, 29'h300, 4'h2, 64'h0, 1'h0);
      run(2'h0, 2'h0, 2'h0, 1'h0, 29'h000, 4'h2, 64'h0, 1'h1);
      run(2'h0, 2'h0, 2'h0, 1'h1, 29'h100, 4'h2, 64'h0, 1'h0);
      run(2'h0, 2'h1, 2'h0, 1'h0, 29'h0ff, 4'h2, 64'h0, 1'h0);
      run(2'h0, 2'h2, 2'h0, 1'h0, 29'h101, 4'h2, 64'h0, 1'h0);
      run(2'h0, 2'h2, 2'h0, 1'h0, 29'h050, 4'h2, 64'h0, 1'h1);
      run(2'h0, 2'h3, 2'h0, 1'h0, 29'h200, 4'h2, 64'h0, 1'h1);
      run(2'h0, 2'h3, 2'h0, 1'h0, 29'h201, 4'h2, 64'h0, 1'h0);
      run(2'h1, 2'h1, 2'h0, 1'h0, 29'h100, 4'h2, 64'h1234, 1'h1);
      run(2'h1, 2'h1, 2'h0, 1'h0, 29'h100, 4'h2, 64'h1235, 1'h0);
      run(2'h1, 2'h1, 2'h0, 1'h0, 29'h100, 4'h3, 64'h551234, 1'h1);
      run(2'h1, 2'h1, 2'h1, 1'h0, 29'h100, 4'h2, 64'h1233, 1'h0);
      run(2'h1, 2'h1, 2'h1, 1'h0, 29'h100, 4'h2, 64'h1300, 1'h1);
      run(2'h1, 2'h1, 2'h2, 1'h0, 29'h100, 4'h2, 64'h1235, 1'h0);
      run(2'h1, 2'h1, 2'h2, 1'h0, 29'h100, 4'h2, 64'h0034, 1'h1);
      run(2'h1, 2'h1, 2'h3, 1'h0, 29'h100, 4'h2, 64'hffff, 1'h1);
      run(2'h1, 2'h1, 2'h3, 1'h0, 29'h100, 4'h3, 64'h010000, 1'h0);
      run(2'h1, 2'h1, 2'h0, 1'h0, 29'h100, 4'h1, 64'h1234, 1'h0);
      run(2'h1, 2'h1, 2'h0, 1'h0, 29'h100, 4'h9, 64'h1234, 1'h0);
      run(2'h1, 2'h1, 2'h0, 1'h0, 29'h100, 4'h8, 64'h1234, 1'h1);
      wr(ct, 32'h0);
      wr(st, 32'h3);
      wr(ct, cf(2'h2, 2'h0, 2'h0, 1'b1, 1'b0, 8'h02));
      src.send(1'b0, 1'b0, 29'h100, 4'h2, 64'h1234);
      rd("count before setting", st, 32'h0104);
      src.send(1'b0, 1'b0, 29'h000, 4'h1, 64'h77);
      repeat (2) @(posedge pclk);
      chk("irq on match", 32'h1, {31'h0, wakeup_irq});
      chk("left filter mode", 32'h0, {31'h0, lp_filter_active});
      rd("status after match", st, 32'h0201);
      rd("group0 ctrl", 12'h040, 32'h20);
      rd("group0 id", 12'h044, 32'h100);
      rd("group0 data low", 12'h048, 32'h1234);
      rd("group0 data high", 12'h04c, 32'h0);
      rd("group1 ctrl", 12'h050, 32'h10);
      rd("group1 data low", 12'h058, 32'h77);
      rd("group2 unused", 12'h064, 32'h0);
      wr(st, 32'h1);
      repeat (2) @(posedge pclk);
      chk("irq cleared", 32'h0, {31'h0, wakeup_irq});
      wr(ct, 32'h0);
      wr(ct, cf(2'h0, 2'h0, 2'h0, 1'b0, 1'b0, 8'h04));
      src.send(1'b0, 1'b1, 29'h100, 4'h2, 64'h1234);
      rd("fd frame ignored", st, 32'h4);
      @(posedge pclk);
      rx_error <= 1'b1;
      tx_error <= 1'b1;
      @(posedge pclk);
      rx_error <= 1'b0;
      tx_error <= 1'b0;
      rd("error counters", `CWF_ERRCNT_ADDR, 32'h1);
      wr(ct, 32'h0);
      wr(ct, cf(2'h3, 2'h1, 2'h0, 1'b0, 1'b0, 8'h02));
      src.send(1'b0, 1'b0, 29'h100, 4'h2, 64'h1234);
      src.send(1'b0, 1'b0, 29'h100, 4'h2, 64'h9999);
      rd("one full match", st, 32'h0104);
      src.send(1'b0, 1'b0, 29'h100, 4'h2, 64'h1234);
      rd("second full match", st, 32'h0205);
      wr(ct, 32'h0);
      wr(st, 32'h3);
      wr(`CWF_TIMEOUT_ADDR, 32'h2);
      wr(ct, cf(2'h0, 2'h0, 2'h0, 1'b0, 1'b0, 8'h04));
      repeat (20) @(posedge pclk);
      rd("before timeout", st, 32'h4);
      repeat (40) @(posedge pclk);
      rd("after timeout", st, 32'h6);
      src.send(1'b0, 1'b0, 29'h100, 4'h2, 64'h0);
      rd("match after timeout", st, 32'h0107);
      wr(ct, 32'h0);
      wr(ct, cf(2'h0, 2'h0, 2'h0, 1'b0, 1'b1, 8'h04));
      repeat (60) @(posedge pclk);
      chk("timeout irq", 32'h1, {31'h0, wakeup_irq});
      chk("woken by timeout", 32'h0, {31'h0, lp_filter_active});
      end_of_test();
   end
endmodule
`default_nettype wire
